// file: design/edge_sync.sv
// two-flop synchroniser with rising edge pulse for a pin or foreign clock
`timescale 1ns/10ps
module edge_sync
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pin,
	output logic level,
	output logic rise
);
	import osc_switch_pkg::*;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} sync_state_t;

	sync_state_t q_r;
	sync_state_t q_nxt;

	// first stage feeds only the second stage
	always_comb
	begin
		q_nxt = q_r;
		q_nxt.s1 = pin;
		q_nxt.s2 = q_r.s1;
		q_nxt.s3 = q_r.s2;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			q_r <= '0;
		else
			q_r <= q_nxt;
	end

	assign level = q_r.s2;
	assign rise = q_r.s2 & ~q_r.s3;

endmodule : edge_sync

// file: design/osc_clock_switch.sv
// system clock source selection, switching and start-up sequencing
`timescale 1ns/10ps
module osc_clock_switch
#(
	parameter int unsigned LOCK_CYCLES = osc_switch_pkg::LOCK_CYCLES,
	parameter int unsigned PERIOD_WIDTH = 20
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire osc_switch_pkg::osc_mode_t osc_mode_cfg,
	input wire logic clock_switch_enable_n,
	input wire logic secondary_osc_enable,
	input wire logic osc_in_pin,
	input wire logic secondary_osc_pin,
	input wire logic osc_out_pin_i,
	output logic osc_out_pin_o,
	output logic osc_out_pin_oe,
	input wire logic port_a_bit_six_out,
	input wire logic port_a_bit_six_oe,
	output logic port_a_bit_six_in,
	output logic cpu_clk_en,
	output logic cpu_frozen,
	output logic exec_ready,
	output logic pll_enable,
	output logic sys_clk_secondary
);
	import osc_switch_pkg::*;

	localparam int unsigned LW = $clog2(LOCK_CYCLES + 1);

	// one-hot sequencer states
	typedef enum logic [7:0] {
		S_CFG = 8'b0000_0001,
		S_STARTUP = 8'b0000_0010,
		S_LOCK = 8'b0000_0100,
		S_RUN_PRI = 8'b0000_1000,
		S_WAIT_FIRST = 8'b0001_0000,
		S_SYNC_SEC = 8'b0010_0000,
		S_RUN_SEC = 8'b0100_0000,
		S_SYNC_PRI = 8'b1000_0000
	} seq_state_t;

	typedef struct packed {
		seq_state_t st;
		osc_mode_t mode;
		logic sw_en_n;
		logic clk_sel;
		logic back;
		logic [10:0] startup_cnt;
		logic [LW-1:0] lock_cnt;
		logic [3:0] sync_cnt;
		logic [1:0] q_phase;
		logic div_half;
		logic div_out;
		logic clk_en;
		logic ready;
		logic [7:0] rdata;
		logic err;
	} state_t;

	state_t q_r;
	state_t q_nxt;

	logic pri_level;
	logic pri_rise;
	logic sec_rise;
	logic gpio_level;
	logic pll_tick;
	logic pri_tick;
	logic pll_on;
	logic switch_ok;
	logic setup;
	logic access;
	logic hit_ctrl;
	logic hit_stat;
	osc_status_t status;

	// primary and secondary oscillators are sampled, never used as clocks
	edge_sync u_pri_sync
	(
		.pclk(pclk),
		.presetn(presetn),
		.pin(osc_in_pin),
		.level(pri_level),
		.rise(pri_rise)
	);

	edge_sync u_sec_sync
	(
		.pclk(pclk),
		.presetn(presetn),
		.pin(secondary_osc_pin),
		.level(),
		.rise(sec_rise)
	);

	// port a bit six input path through the pin pad
	edge_sync u_gpio_sync
	(
		.pclk(pclk),
		.presetn(presetn),
		.pin(osc_out_pin_i),
		.level(gpio_level),
		.rise()
	);

	// four ticks per crystal period stand in for the multiplied clock
	quad_tick #(
		.MULT(PLL_MULT),
		.WIDTH(PERIOD_WIDTH)
	) u_pll
	(
		.pclk(pclk),
		.presetn(presetn),
		.rise(pri_rise & pll_on),
		.tick(pll_tick)
	);

	// mode decode, only valid once the fuses have been captured
	assign pll_on = is_pll(q_r.mode) && (q_r.st != S_CFG);
	assign pri_tick = pll_on ? pll_tick : pri_rise;
	assign switch_ok = !q_r.sw_en_n && secondary_osc_enable;

	// apb phase and address decode
	assign setup = psel & ~penable;
	assign access = psel & penable;
	assign hit_ctrl = (paddr == ADDR_OSC_CONTROL);
	assign hit_stat = (paddr == ADDR_OSC_STATUS);

	// status word assembled from live state
	always_comb
	begin
		status.pll_enable = pll_on;
		status.exec_ready = q_r.ready;
		status.frozen = cpu_frozen;
		status.on_secondary = sys_clk_secondary;
		status.switch_en_n = q_r.sw_en_n;
		status.mode = q_r.mode;
	end

	// next state of the whole block
	always_comb
	begin
		q_nxt = q_r;
		q_nxt.clk_en = 1'b0;
		q_nxt.err = 1'b0;

		// read data latched in the setup cycle, so prdata comes from a flop
		if (setup)
		begin
			q_nxt.rdata = 8'h00;
			q_nxt.err = !(hit_ctrl || hit_stat);
			if (hit_ctrl)
				q_nxt.rdata = {7'h00, q_r.clk_sel};
			else if (hit_stat)
				q_nxt.rdata = status;
		end
		else
		begin
			q_nxt.err = q_r.err;
		end

		// select bit write, only bit zero of the low byte lane matters
		if (access && pwrite && hit_ctrl && pstrb[0])
			q_nxt.clk_sel = pwdata[SELECT_BIT] & switch_ok;
		// a disabled secondary or fuse keeps the bit cleared at all times
		if (!switch_ok)
			q_nxt.clk_sel = 1'b0;

		// divide-by-four clock output: toggle every second primary edge
		if (pri_rise)
		begin
			q_nxt.div_half = ~q_r.div_half;
			if (q_r.div_half)
				q_nxt.div_out = ~q_r.div_out;
		end

		unique case (q_r.st)
			// capture the programmed fuses once after reset release
			S_CFG:
			begin
				q_nxt.mode = osc_mode_cfg;
				q_nxt.sw_en_n = clock_switch_enable_n;
				q_nxt.back = 1'b0;
				q_nxt.startup_cnt = '0;
				q_nxt.lock_cnt = '0;
				if (needs_startup(osc_mode_cfg))
					q_nxt.st = S_STARTUP;
				else
				begin
					q_nxt.st = S_RUN_PRI;
					q_nxt.ready = 1'b1;
				end
			end
			// start-up timer counts raw input edges, not multiplied ones
			S_STARTUP:
			begin
				if (pri_rise)
				begin
					q_nxt.startup_cnt = q_r.startup_cnt + 1'b1;
					if (q_r.startup_cnt == 11'(STARTUP_EDGES - 1))
					begin
						q_nxt.startup_cnt = '0;
						q_nxt.lock_cnt = '0;
						q_nxt.sync_cnt = '0;
						if (is_pll(q_r.mode))
							q_nxt.st = S_LOCK;
						else if (q_r.back)
							q_nxt.st = S_SYNC_PRI;
						else
						begin
							q_nxt.st = S_RUN_PRI;
							q_nxt.ready = 1'b1;
						end
					end
				end
			end
			// lock wait in bus clock cycles, execution held meanwhile
			S_LOCK:
			begin
				q_nxt.lock_cnt = q_r.lock_cnt + 1'b1;
				if (q_r.lock_cnt == LW'(LOCK_CYCLES - 1))
				begin
					q_nxt.lock_cnt = '0;
					q_nxt.sync_cnt = '0;
					if (q_r.back)
						q_nxt.st = S_SYNC_PRI;
					else
					begin
						q_nxt.st = S_RUN_PRI;
						q_nxt.ready = 1'b1;
					end
				end
			end
			// running from primary, quarter phases advance on each tick
			S_RUN_PRI:
			begin
				q_nxt.back = 1'b0;
				if (pri_tick)
				begin
					q_nxt.clk_en = 1'b1;
					q_nxt.q_phase = q_r.q_phase + 1'b1;
				end
				if (q_r.clk_sel)
					q_nxt.st = S_WAIT_FIRST;
			end
			// keep clocking until the processor has just entered its first quarter
			S_WAIT_FIRST:
			begin
				if (pri_tick)
				begin
					q_nxt.clk_en = 1'b1;
					q_nxt.q_phase = q_r.q_phase + 1'b1;
					if (q_r.q_phase == 2'h3)
					begin
						q_nxt.st = S_SYNC_SEC;
						q_nxt.sync_cnt = '0;
					end
				end
				if (!q_r.clk_sel)
					q_nxt.st = S_RUN_PRI;
			end
			// eight secondary edges, then run; no extra delay afterwards
			S_SYNC_SEC:
			begin
				if (sec_rise)
				begin
					q_nxt.sync_cnt = q_r.sync_cnt + 1'b1;
					if (q_r.sync_cnt == 4'(SYNC_EDGES - 1))
						q_nxt.st = S_RUN_SEC;
				end
				// secondary lost mid-sync: primary never stopped, fall back
				if (!q_r.clk_sel)
					q_nxt.st = S_RUN_PRI;
			end
			// running from the secondary oscillator
			S_RUN_SEC:
			begin
				if (sec_rise)
				begin
					q_nxt.clk_en = 1'b1;
					q_nxt.q_phase = q_r.q_phase + 1'b1;
				end
				if (!q_r.clk_sel)
				begin
					q_nxt.back = 1'b1;
					q_nxt.sync_cnt = '0;
					q_nxt.startup_cnt = '0;
					if (needs_startup(q_r.mode))
						q_nxt.st = S_STARTUP;
					else
						q_nxt.st = S_SYNC_PRI;
				end
			end
			// eight ticks of the returning primary (multiplied ticks in pll mode) before it drives the core
			S_SYNC_PRI:
			begin
				if (pri_tick)
				begin
					q_nxt.sync_cnt = q_r.sync_cnt + 1'b1;
					if (q_r.sync_cnt == 4'(SYNC_EDGES - 1))
					begin
						q_nxt.st = S_RUN_PRI;
						q_nxt.back = 1'b0;
					end
				end
			end
			default:
			begin
				q_nxt.st = S_CFG;
			end
		endcase
	end

	// single register stage for all block state
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			q_r <= '0;
			q_r.st <= S_CFG;
			q_r.mode <= low_power_crystal_mode;
			q_r.sw_en_n <= 1'b1; // erased fuse: switching off until captured
			q_r.clk_sel <= OSC_CONTROL_RESET[SELECT_BIT];
		end
		else
		begin
			q_r <= q_nxt;
		end
	end

	// apb answer: zero wait states, error on unmapped addresses
	assign pready = access;
	assign pslverr = access & q_r.err;
	assign prdata = {24'h00_0000, q_r.rdata};

	// core clock gating and sequencer view
	assign cpu_clk_en = q_r.clk_en;
	assign cpu_frozen = !(q_r.st == S_RUN_PRI || q_r.st == S_WAIT_FIRST ||
		q_r.st == S_RUN_SEC);
	assign exec_ready = q_r.ready;
	assign pll_enable = pll_on;
	assign sys_clk_secondary = (q_r.st == S_RUN_SEC);

	// second oscillator pin: divided clock, port bit, or left to the crystal
	always_comb
	begin
		osc_out_pin_o = 1'b0;
		osc_out_pin_oe = 1'b0;
		port_a_bit_six_in = 1'b0;
		if (q_r.st != S_CFG && has_clkout(q_r.mode))
		begin
			osc_out_pin_o = q_r.div_out;
			osc_out_pin_oe = 1'b1;
		end
		else if (q_r.st != S_CFG && has_gpio(q_r.mode))
		begin
			osc_out_pin_o = port_a_bit_six_out;
			osc_out_pin_oe = port_a_bit_six_oe;
			port_a_bit_six_in = gpio_level;
		end
	end

	// pri_level has no consumer and is only tied off to unused_level
	logic unused_level;
	assign unused_level = pri_level;

endmodule : osc_clock_switch

// file: design/osc_switch_pkg.sv
// shared constants, types and mode decoders for the system clock switch
package osc_switch_pkg;

	// register map, byte addresses on the apb bus
	localparam logic [11:0] ADDR_OSC_CONTROL = 12'h000;
	localparam logic [11:0] ADDR_OSC_STATUS = 12'h004;
	localparam logic [7:0] OSC_CONTROL_RESET = 8'h00;
	localparam int unsigned SELECT_BIT = 0;

	// timing: bus clock rate, start-up and lock figures
	localparam int unsigned PCLK_MHZ = 100;
	localparam int unsigned STARTUP_EDGES = 1024;
	localparam int unsigned SYNC_EDGES = 8;
	localparam int unsigned CLKOUT_DIV = 4;
	localparam int unsigned PLL_MULT = 4;
	localparam int unsigned LOCK_TIME_US = 2000;
	localparam int unsigned LOCK_CYCLES = LOCK_TIME_US * PCLK_MHZ;

	// oscillator mode field, encoding fixed at programming time
	typedef enum logic [2:0] {
		low_power_crystal_mode = 3'h0,
		standard_crystal_mode = 3'h1,
		high_speed_crystal_mode = 3'h2,
		high_speed_pll_mode = 3'h3,
		resistor_capacitor_mode = 3'h4,
		resistor_capacitor_io_mode = 3'h5,
		external_clock_mode = 3'h6,
		external_clock_io_mode = 3'h7
	} osc_mode_t;

	// status word as seen by software
	typedef struct packed {
		logic pll_enable;
		logic exec_ready;
		logic frozen;
		logic on_secondary;
		logic switch_en_n;
		osc_mode_t mode;
	} osc_status_t;

	// crystal style modes need the start-up timer
	function automatic logic needs_startup(input osc_mode_t m);
		needs_startup = (m == low_power_crystal_mode) || (m == standard_crystal_mode) ||
			(m == high_speed_crystal_mode) || (m == high_speed_pll_mode);
	endfunction : needs_startup

	function automatic logic is_pll(input osc_mode_t m);
		is_pll = (m == high_speed_pll_mode);
	endfunction : is_pll

	// modes that drive the divided clock onto the second pin
	function automatic logic has_clkout(input osc_mode_t m);
		has_clkout = (m == resistor_capacitor_mode) || (m == external_clock_mode);
	endfunction : has_clkout

	// modes that hand the second pin to port a bit six
	function automatic logic has_gpio(input osc_mode_t m);
		has_gpio = (m == resistor_capacitor_io_mode) || (m == external_clock_io_mode);
	endfunction : has_gpio

endpackage : osc_switch_pkg

// file: design/quad_tick.sv
// frequency multiplier: spreads several ticks evenly over each input period
`timescale 1ns/10ps
module quad_tick
#(
	parameter int unsigned MULT = 4,
	parameter int unsigned WIDTH = 20
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic rise,
	output logic tick
);
	import osc_switch_pkg::*;

	typedef struct packed {
		logic [WIDTH-1:0] period;
		logic [WIDTH-1:0] step;
		logic [WIDTH-1:0] sub;
		logic [3:0] left;
		logic tick;
	} mult_state_t;

	mult_state_t q_r;
	mult_state_t q_nxt;

	// measures the last period, then emits a tick every period/MULT cycles
	always_comb
	begin
		q_nxt = q_r;
		q_nxt.tick = 1'b0;
		q_nxt.period = q_r.period + 1'b1;
		q_nxt.sub = q_r.sub + 1'b1;
		if (rise)
		begin
			q_nxt.period = '0;
			q_nxt.step = WIDTH'(q_r.period / MULT);
			q_nxt.sub = '0;
			q_nxt.left = 4'(MULT - 1);
			q_nxt.tick = 1'b1;
		end
		else if (q_r.left != 4'h0 && q_r.sub >= q_r.step)
		begin
			q_nxt.sub = '0;
			q_nxt.left = q_r.left - 1'b1;
			q_nxt.tick = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			q_r <= '0;
		else
			q_r <= q_nxt;
	end

	assign tick = q_r.tick;

endmodule : quad_tick

// file: testbench/osc_clock_switch_monitor.sv
// concurrent checks on the clock switch ports
`timescale 1ns/10ps
module osc_clock_switch_monitor
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire osc_switch_pkg::osc_mode_t osc_mode_cfg,
	input wire logic clock_switch_enable_n,
	input wire logic secondary_osc_pin,
	input wire logic osc_out_pin_oe,
	input wire logic port_a_bit_six_oe,
	input wire logic cpu_clk_en,
	input wire logic cpu_frozen,
	input wire logic exec_ready,
	input wire logic pll_enable,
	input wire logic sys_clk_secondary
);
	import osc_switch_pkg::*;
	logic [2:0] sec_sync_r;
	logic [4:0] sec_cnt_r;

	// count synced secondary rises while frozen; saturates so it never wraps
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sec_sync_r <= 3'h0;
			sec_cnt_r <= 5'h00;
		end
		else
		begin
			sec_sync_r <= {sec_sync_r[1:0], secondary_osc_pin};
			if (!cpu_frozen)
				sec_cnt_r <= 5'h00;
			else if (sec_sync_r[1] && !sec_sync_r[2] && sec_cnt_r != 5'h1f)
				sec_cnt_r <= sec_cnt_r + 5'h01;
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// steps of a transfer and of a switch
	sequence ctl_read;
		psel && penable && !pwrite && paddr == ADDR_OSC_CONTROL;
	endsequence
	sequence frozen_run;
		cpu_frozen [*2];
	endsequence
	sequence sync_done;
		$rose(sys_clk_secondary);
	endsequence

	AST_CTL_UPPER_ZERO: assert property (ctl_read |-> prdata[31:1] == 31'h0)
		else $error("control upper bits not zero");
	AST_PLL_ONLY_FAST: assert property (pll_enable |-> osc_mode_cfg == high_speed_pll_mode)
		else $error("pll on outside pll mode");
	AST_FUSE_BLOCKS: assert property (clock_switch_enable_n |-> !sys_clk_secondary)
		else $error("switched with fuse erased");
	AST_FROZEN_NO_CLK: assert property (frozen_run |-> !cpu_clk_en)
		else $error("clock pulse while frozen");
	AST_NO_EXEC_NO_CLK: assert property (!exec_ready |-> !cpu_clk_en)
		else $error("clock pulse before start-up done");
	AST_SYNC_EIGHT: assert property (sync_done |-> sec_cnt_r >= 5'h08 && $past(cpu_frozen))
		else $error("secondary used before eight edges");
	AST_CLKOUT_ON: assert property ((osc_mode_cfg inside {resistor_capacitor_mode,
		external_clock_mode}) && $past(exec_ready, 3) |-> osc_out_pin_oe)
		else $error("divided clock not driven");
	AST_IO_HANDOFF: assert property ((osc_mode_cfg inside {resistor_capacitor_io_mode,
		external_clock_io_mode}) && !port_a_bit_six_oe && !$past(port_a_bit_six_oe)
		|-> !osc_out_pin_oe)
		else $error("io pin driven without port enable");
endmodule : osc_clock_switch_monitor

bind osc_clock_switch osc_clock_switch_monitor mon
(
	.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
	.pwrite(pwrite), .prdata(prdata), .osc_mode_cfg(osc_mode_cfg),
	.clock_switch_enable_n(clock_switch_enable_n), .secondary_osc_pin(secondary_osc_pin),
	.osc_out_pin_oe(osc_out_pin_oe), .port_a_bit_six_oe(port_a_bit_six_oe),
	.cpu_clk_en(cpu_clk_en), .cpu_frozen(cpu_frozen), .exec_ready(exec_ready),
	.pll_enable(pll_enable), .sys_clk_secondary(sys_clk_secondary)
);

// file: testbench/osc_source_model.sv
// primary and secondary oscillator sources
`timescale 1ns/10ps
module osc_source_model
#(
	parameter real PRI_HALF = 50.0,
	parameter real SEC_HALF = 230.0
)
(
	input wire logic sec_run,
	output logic osc_in_pin,
	output logic secondary_osc_pin
);
	// primary runs free; secondary stops low when its enable drops
	initial
	begin
		osc_in_pin = 1'b0;
		forever #(PRI_HALF) osc_in_pin = ~osc_in_pin;
	end
	initial
	begin
		secondary_osc_pin = 1'b0;
		forever #(SEC_HALF) secondary_osc_pin = sec_run & ~secondary_osc_pin;
	end
endmodule : osc_source_model

// file: testbench/tb_system_clock_select_switch.sv
// self-checking bench for the system clock source switch
`timescale 1ns/10ps
module tb_system_clock_select_switch;
	import osc_switch_pkg::*;
	localparam int LOCK = 50;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic pready, pslverr, err, fuse_n = 1'b0, sec_en = 1'b1;
	logic pa_out = 1'b0, pa_oe = 1'b0, ext_lvl = 1'b0;
	logic pin_o, pin_oe, pa_in, clk_en, frozen, exec_rdy, pll_en, on_sec, osc_in, sec_pin;
	osc_mode_t mode = external_clock_mode;
	int fails = 0, compares = 0, n;
	wire pin_i = pin_oe ? pin_o : ext_lvl;

	always #5 pclk = ~pclk;

	osc_clock_switch #(.LOCK_CYCLES(LOCK)) dut
	(
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .osc_mode_cfg(mode), .clock_switch_enable_n(fuse_n),
		.secondary_osc_enable(sec_en), .osc_in_pin(osc_in), .secondary_osc_pin(sec_pin),
		.osc_out_pin_i(pin_i), .osc_out_pin_o(pin_o), .osc_out_pin_oe(pin_oe),
		.port_a_bit_six_out(pa_out), .port_a_bit_six_oe(pa_oe), .port_a_bit_six_in(pa_in),
		.cpu_clk_en(clk_en), .cpu_frozen(frozen), .exec_ready(exec_rdy),
		.pll_enable(pll_en), .sys_clk_secondary(on_sec)
	);
	osc_source_model src (.sec_run(sec_en), .osc_in_pin(osc_in), .secondary_osc_pin(sec_pin));

	task automatic stop_test;
		$display("fails=%0d compares=%0d", fails, compares);
		if (fails == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stop_test

	task automatic timeout;
		fails++;
		$display("BAD %0t wait ran out", $time);
		stop_test();
	endtask : timeout

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			fails++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic check_range(input int v, input int lo, input int hi);
		compares++;
		if (v < lo || v > hi)
		begin
			fails++;
			$display("BAD %0t count %0d outside %0d..%0d", $time, v, lo, hi);
		end
	endtask : check_range

	// one apb transfer; request held until pready is seen at an edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
		begin
			if (++k > 20)
				timeout();
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// bounded wait on exec ready (0), secondary (1), frozen (2); n holds the cycles
	task automatic wait_for(input int sel, input logic v);
		n = 0;
		while ((sel == 0 ? exec_rdy : (sel == 1 ? on_sec : frozen)) !== v)
		begin
			@(posedge pclk);
			if (++n > 30000)
				timeout();
		end
	endtask : wait_for

	task automatic do_reset(input osc_mode_t m, input logic f);
		@(posedge pclk);
		presetn <= 1'b0;
		mode <= m;
		fuse_n <= f;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
	endtask : do_reset

	task automatic t_regs;
		do_reset(external_clock_mode, 1'b0);
		apb(1'b0, ADDR_OSC_CONTROL, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		apb(1'b1, ADDR_OSC_CONTROL, 32'hffff_fffe);
		apb(1'b0, ADDR_OSC_CONTROL, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		apb(1'b0, ADDR_OSC_STATUS, 32'h0000_0000);
		check(rd, 32'h0000_0046);
		apb(1'b0, 12'h008, 32'h0000_0000);
		check({31'h0, err}, 32'h0000_0001);
	endtask : t_regs

	task automatic t_switch(input int lo, input int hi);
		apb(1'b1, ADDR_OSC_CONTROL, 32'h0000_0001);
		wait_for(1, 1'b1);
		check_range(n, 280, 600);
		apb(1'b0, ADDR_OSC_CONTROL, 32'h0000_0000);
		check(rd, 32'h0000_0001);
		check({31'h0, frozen}, 32'h0000_0000);
		apb(1'b1, ADDR_OSC_CONTROL, 32'h0000_0000);
		// leaving the secondary is immediate; the return ends when the core runs again
		wait_for(1, 1'b0);
		wait_for(2, 1'b0);
		check_range(n, lo, hi);
	endtask : t_switch

	task automatic t_refuse;
		sec_en <= 1'b0;
		apb(1'b1, ADDR_OSC_CONTROL, 32'h0000_0001);
		apb(1'b0, ADDR_OSC_CONTROL, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		sec_en <= 1'b1;
		do_reset(external_clock_mode, 1'b1);
		apb(1'b1, ADDR_OSC_CONTROL, 32'h0000_0001);
		apb(1'b0, ADDR_OSC_CONTROL, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		repeat (600) @(posedge pclk);
		check({31'h0, on_sec}, 32'h0000_0000);
	endtask : t_refuse

	// every mode: start-up, pin ownership and divided clock
	task automatic t_pins;
		int k;
		logic prev;
		for (int m = 0; m < 8; m++)
		begin
			pa_oe <= 1'b1;
			pa_out <= 1'b1;
			do_reset(osc_mode_t'(m), 1'b0);
			repeat (40) @(posedge pclk);
			check({31'h0, exec_rdy}, {31'h0, m > 3});
			check({31'h0, pin_oe}, {31'h0, m > 3});
			k = 0;
			prev = pin_o;
			repeat (800)
			begin
				@(posedge pclk);
				k += (pin_o !== prev);
				prev = pin_o;
			end
			check_range(k, (m == 4 || m == 6) ? 38 : 0, (m == 4 || m == 6) ? 42 : 0);
			if (m == 5 || m == 7)
			begin
				check({31'h0, pa_in}, 32'h0000_0001);
				pa_oe <= 1'b0;
				repeat (6) @(posedge pclk);
				check({31'h0, pin_oe}, 32'h0000_0000);
				check({31'h0, pa_in}, 32'h0000_0000);
			end
		end
		pa_oe <= 1'b0;
	endtask : t_pins

	task automatic t_crystal;
		do_reset(standard_crystal_mode, 1'b0);
		wait_for(0, 1'b1);
		check_range(n, 10230, 10500);
		t_switch(10230, 10700);
	endtask : t_crystal

	task automatic t_pll;
		do_reset(high_speed_pll_mode, 1'b0);
		wait_for(0, 1'b1);
		check_range(n, 10230 + LOCK, 10600);
		check({31'h0, pll_en}, 32'h0000_0001);
		repeat (100) @(posedge pclk);
		n = 0;
		repeat (1000)
		begin
			@(posedge pclk);
			n += (clk_en === 1'b1);
		end
		check_range(n, 396, 404);
		t_switch(10230 + LOCK, 10800);
	endtask : t_pll

	initial
	begin
		t_regs();
		t_switch(60, 120);
		t_refuse();
		t_pins();
		t_crystal();
		t_pll();
		stop_test();
	end
endmodule : tb_system_clock_select_switch
